// File: rtl/plam_pkg.sv
// constants and types shared by the part life alarm monitor
package plam_pkg;
   localparam int CLK_KHZ            = 25000;
   localparam int DC_TIME_MS         = 1000;
   localparam int DC_CYCLES          = CLK_KHZ * DC_TIME_MS;
   localparam int INRUSH_PER_PCT     = 10000;

   localparam logic [7:0] ADR_STATUS     = 8'h00;
   localparam logic [7:0] ADR_INRUSH     = 8'h04;
   localparam logic [7:0] ADR_CTRL_CAP   = 8'h08;
   localparam logic [7:0] ADR_MAIN_CAP   = 8'h0C;
   localparam logic [7:0] ADR_MEAS_CTRL  = 8'h10;
   localparam logic [7:0] ADR_FUNC_A     = 8'h14;
   localparam logic [7:0] ADR_FUNC_B     = 8'h18;
   localparam logic [7:0] ADR_FUNC_C     = 8'h1C;
   localparam logic [7:0] ADR_IRQ_STAT   = 8'h20;
   localparam logic [7:0] ADR_IRQ_CLR    = 8'h24;
   localparam logic [7:0] ADR_IRQ_EN     = 8'h28;

   localparam int BIT_CTRL_CAP = 0;
   localparam int BIT_MAIN_CAP = 1;
   localparam int BIT_FAN      = 2;
   localparam int BIT_INRUSH   = 3;
   localparam int BIT_MEAS_END = 4;
   localparam int IRQ_W        = 5;

   localparam logic [6:0] PCT_FULL        = 7'h64;
   localparam logic [6:0] PCT_INRUSH_LIM  = 7'h0A;
   localparam logic [6:0] PCT_CTRL_LIM    = 7'h0A;
   localparam logic [6:0] PCT_MAIN_LIM    = 7'h55;
   localparam logic [6:0] PCT_FAN_ONE     = 7'h28;
   localparam logic [6:0] PCT_FAN_MULTI   = 7'h32;

   localparam logic [7:0] CODE_ALARM_SRC  = 8'h5A;
   localparam logic [7:0] CODE_ALARM_SINK = 8'hBE;
   localparam logic [7:0] FUNC_RESET      = 8'h00;

   localparam logic [3:0] MC_IDLE   = 4'h0;
   localparam logic [3:0] MC_START  = 4'h1;
   localparam logic [3:0] MC_MEAS   = 4'h2;
   localparam logic [3:0] MC_DONE   = 4'h3;
   localparam logic [3:0] MC_FORCED = 4'h8;
   localparam logic [3:0] MC_ERROR  = 4'h9;

   typedef enum logic [2:0] {S_IDLE, S_START, S_MEAS, S_DONE, S_FORCED, S_ERROR} plam_meas_t;
endpackage

// File: rtl/plam_top.sv
// part life alarm monitor with wishbone register slave
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
// Notes on behaviour
// [RULE_01] status word bits: 3 inrush, 2 fan, 1 main cap, 0 control cap
// [RULE_02] life alarm is high while any of the four flags is set
// [RULE_03] alarm reaches a terminal only when its code is 90 or 190
// [RULE_04] inrush life drops one percent per 10,000 contact closures
// [RULE_05] inrush life at 10 percent sets bit 3 and the alarm
// [RULE_06] control capacitor life counts down from 100 on wear steps
// [RULE_07] control capacitor life below 10 percent sets bit 0
// [RULE_08] main capacitor life updated after each completed measurement
// [RULE_09] main capacitor life at or below 85 percent sets bit 1
// [RULE_10] control codes 0,1,2,3,8,9; only 0 and 1 are writable
// [RULE_11] code 1 starts measurement at the next power-down
// [RULE_12] measurement drives DC on motor outputs for one second
// [RULE_13] run, shutoff, fault, power return, bad motor end it as 8 or 9
// [RULE_14] operator rewrites 1 if it stays at measuring after power return
// [RULE_15] fan speed at or below 40 percent sets bit 2 and fan fault
// [RULE_16] with several fans, any fan at or below 50 percent is a fault
// [RULE_17] the three life values are read-only, 0 to 100, reset to 100
// [RULE_18] sink code drives the terminal inverted from source code
module plam_top
   import plam_pkg::*;
#(
   parameter int NUM_FANS       = 1,
   parameter int DC_CYC         = DC_CYCLES,
   parameter int INRUSH_PER     = INRUSH_PER_PCT
)(
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_wb_cyc,
   input  wire logic                  i_wb_stb,
   input  wire logic                  i_wb_we,
   input  wire logic [7:0]            i_wb_adr,
   input  wire logic [31:0]           i_wb_dat,
   input  wire logic [3:0]            i_wb_sel,
   output logic      [31:0]           o_wb_dat,
   output logic                       o_wb_ack,
   input  wire logic                  i_inrush_close,
   input  wire logic                  i_ctrl_cap_wear,
   input  wire logic [6:0]            i_main_cap_meas_pct,
   input  wire logic [NUM_FANS*7-1:0] i_fan_speed_pct,
   input  wire logic                  i_power_on,
   input  wire logic                  i_run_cmd,
   input  wire logic                  i_output_shutoff_in,
   input  wire logic                  i_fault_stop,
   input  wire logic                  i_motor_present,
   input  wire logic                  i_motor_rotating,
   output logic                       o_dc_inject,
   output logic                       o_life_alarm_out,
   output logic      [2:0]            o_term_out,
   output logic                       o_fan_fault_indication,
   output logic                       o_irq
);

   function automatic logic [3:0] meas_code(input plam_meas_t s);
      unique case (s)
         S_IDLE:   meas_code = MC_IDLE;
         S_START:  meas_code = MC_START;
         S_MEAS:   meas_code = MC_MEAS;
         S_DONE:   meas_code = MC_DONE;
         S_FORCED: meas_code = MC_FORCED;
         S_ERROR:  meas_code = MC_ERROR;
         default:  meas_code = MC_IDLE;
      endcase
   endfunction

   function automatic logic term_drive(input logic [7:0] code, input logic alarm);
      if (code == CODE_ALARM_SRC)
         term_drive = alarm;
      else if (code == CODE_ALARM_SINK)
         term_drive = ~alarm;
      else
         term_drive = 1'b0;
   endfunction

   logic                ack_reg;
   logic [31:0]         rdat_reg;
   logic [6:0]          inrush_life_pct_reg;
   logic [6:0]          ctrl_cap_life_pct_reg;
   logic [6:0]          main_cap_life_pct_reg;
   logic [31:0]         inrush_cnt_reg;
   logic [31:0]         dc_cnt_reg;
   logic [7:0]          func_reg [3];
   logic [IRQ_W-1:0]    irq_stat_reg;
   logic [IRQ_W-1:0]    irq_en_reg;
   logic [3:0]          flags_prev_reg;
   logic                power_prev_reg;
   plam_meas_t          meas_reg;
   plam_meas_t          meas_next;
   logic [3:0]          life_status_word;
   logic                fan_low;
   logic                wr;
   logic                wr_ctrl;
   logic                pdown;
   logic                pup;
   logic                meas_end;
   logic                inrush_wrap;
   logic [IRQ_W-1:0]    irq_evt;

   assign wr          = i_wb_cyc & i_wb_stb & i_wb_we & ack_reg & i_wb_sel[0];
   assign wr_ctrl     = wr & (i_wb_adr == ADR_MEAS_CTRL)
                        & (i_wb_dat[3:0] == MC_IDLE || i_wb_dat[3:0] == MC_START); // RULE_10
   assign pdown       = power_prev_reg & ~i_power_on;
   assign pup         = ~power_prev_reg & i_power_on;
   assign inrush_wrap = i_inrush_close && (inrush_cnt_reg == 32'(INRUSH_PER - 1));

   always_comb
   begin
      fan_low = 1'b0;
      for (int f = 0; f < NUM_FANS; f++)
      begin
         if (i_fan_speed_pct[f*7 +: 7] <= ((NUM_FANS > 1) ? PCT_FAN_MULTI : PCT_FAN_ONE)) // RULE_15 RULE_16
            fan_low = 1'b1;
      end
   end

   always_comb
   begin
      life_status_word[BIT_INRUSH]   = inrush_life_pct_reg <= PCT_INRUSH_LIM; // RULE_01 RULE_05
      life_status_word[BIT_FAN]      = fan_low;                               // RULE_15
      life_status_word[BIT_MAIN_CAP] = main_cap_life_pct_reg <= PCT_MAIN_LIM; // RULE_09
      life_status_word[BIT_CTRL_CAP] = ctrl_cap_life_pct_reg < PCT_CTRL_LIM;  // RULE_07
   end

   assign o_life_alarm_out       = |life_status_word; // RULE_02
   assign o_fan_fault_indication = fan_low;           // RULE_15
   assign o_dc_inject            = meas_reg == S_MEAS; // RULE_12

   always_comb
   begin
      for (int t = 0; t < 3; t++)
         o_term_out[t] = term_drive(func_reg[t], o_life_alarm_out); // RULE_03 RULE_18
   end

   // wishbone slave: ack one cycle after request, write on the ack edge
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= i_wb_cyc & i_wb_stb & ~ack_reg;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         rdat_reg <= 32'h0000_0000;
      else if (i_wb_cyc & i_wb_stb & ~i_wb_we & ~ack_reg)
      begin
         unique case (i_wb_adr)
            ADR_STATUS:    rdat_reg <= {28'h000_0000, life_status_word};        // RULE_01
            ADR_INRUSH:    rdat_reg <= {25'h000_0000, inrush_life_pct_reg};     // RULE_17
            ADR_CTRL_CAP:  rdat_reg <= {25'h000_0000, ctrl_cap_life_pct_reg};   // RULE_17
            ADR_MAIN_CAP:  rdat_reg <= {25'h000_0000, main_cap_life_pct_reg};   // RULE_17
            ADR_MEAS_CTRL: rdat_reg <= {28'h000_0000, meas_code(meas_reg)};     // RULE_10
            ADR_FUNC_A:    rdat_reg <= {24'h00_0000, func_reg[0]};
            ADR_FUNC_B:    rdat_reg <= {24'h00_0000, func_reg[1]};
            ADR_FUNC_C:    rdat_reg <= {24'h00_0000, func_reg[2]};
            ADR_IRQ_STAT:  rdat_reg <= {27'h000_0000, irq_stat_reg};
            ADR_IRQ_EN:    rdat_reg <= {27'h000_0000, irq_en_reg};
            default:       rdat_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdat_reg;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         func_reg[0] <= FUNC_RESET;
         func_reg[1] <= FUNC_RESET;
         func_reg[2] <= FUNC_RESET;
         irq_en_reg  <= '0;
      end
      else if (wr)
      begin
         if (i_wb_adr == ADR_FUNC_A)
            func_reg[0] <= i_wb_dat[7:0];
         if (i_wb_adr == ADR_FUNC_B)
            func_reg[1] <= i_wb_dat[7:0];
         if (i_wb_adr == ADR_FUNC_C)
            func_reg[2] <= i_wb_dat[7:0];
         if (i_wb_adr == ADR_IRQ_EN)
            irq_en_reg <= i_wb_dat[IRQ_W-1:0];
      end
   end

   // inrush contact closures
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         inrush_cnt_reg      <= 32'h0000_0000;
         inrush_life_pct_reg <= PCT_FULL;
      end
      else if (i_inrush_close)
      begin
         inrush_cnt_reg <= inrush_wrap ? 32'h0000_0000 : inrush_cnt_reg + 32'h0000_0001; // RULE_04
         if (inrush_wrap && inrush_life_pct_reg != 7'h00)
            inrush_life_pct_reg <= inrush_life_pct_reg - 7'h01; // RULE_04
      end
   end

   // control capacitor wear steps from the thermal model
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         ctrl_cap_life_pct_reg <= PCT_FULL;
      else if (i_ctrl_cap_wear && ctrl_cap_life_pct_reg != 7'h00)
         ctrl_cap_life_pct_reg <= ctrl_cap_life_pct_reg - 7'h01; // RULE_06
   end

   // power-down capacitor measurement
   always_comb
   begin
      meas_next = meas_reg;
      unique case (meas_reg)
         S_START:
            if (pdown) // RULE_11
            begin
               if (i_fault_stop || i_output_shutoff_in)
                  meas_next = S_FORCED; // RULE_13
               else if (!i_motor_present || i_motor_rotating)
                  meas_next = S_ERROR; // RULE_13
               else
                  meas_next = S_MEAS;
            end
         S_MEAS:
            if (i_run_cmd || i_output_shutoff_in || i_fault_stop || pup)
               meas_next = S_FORCED; // RULE_13
            else if (!i_motor_present || i_motor_rotating)
               meas_next = S_ERROR; // RULE_13
            else if (dc_cnt_reg == 32'(DC_CYC - 1))
               meas_next = S_DONE; // RULE_12
         default: meas_next = meas_reg;
      endcase
      if (wr_ctrl) // RULE_14
         meas_next = (i_wb_dat[3:0] == MC_START) ? S_START : S_IDLE;
   end

   assign meas_end = (meas_reg == S_MEAS) && (meas_next != S_MEAS);

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         meas_reg       <= S_IDLE;
         power_prev_reg <= 1'b1;
      end
      else
      begin
         meas_reg       <= meas_next;
         power_prev_reg <= i_power_on;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         dc_cnt_reg <= 32'h0000_0000;
      else if (meas_reg == S_MEAS)
         dc_cnt_reg <= dc_cnt_reg + 32'h0000_0001; // RULE_12
      else
         dc_cnt_reg <= 32'h0000_0000;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         main_cap_life_pct_reg <= PCT_FULL;
      else if (meas_end && meas_next == S_DONE && !wr_ctrl)
         main_cap_life_pct_reg <= (i_main_cap_meas_pct > PCT_FULL) ? PCT_FULL
                                  : i_main_cap_meas_pct; // RULE_08
   end

   // interrupts: rising life flags and end of measurement; set beats clear
   assign irq_evt = {meas_end, life_status_word & ~flags_prev_reg};

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         irq_stat_reg   <= '0;
         flags_prev_reg <= 4'h0;
      end
      else
      begin
         flags_prev_reg <= life_status_word;
         if (wr && i_wb_adr == ADR_IRQ_CLR)
            irq_stat_reg <= (irq_stat_reg & ~i_wb_dat[IRQ_W-1:0]) | irq_evt;
         else
            irq_stat_reg <= irq_stat_reg | irq_evt;
      end
   end

   assign o_irq = |(irq_stat_reg & irq_en_reg);

   property p_status_map;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      life_status_word[BIT_INRUSH] == (inrush_life_pct_reg <= PCT_INRUSH_LIM)
      && life_status_word[BIT_FAN] == fan_low;
   endproperty
   a_status_map: assert property (p_status_map) else $error("status word bit map wrong"); // RULE_01

   property p_alarm_any;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_life_alarm_out == (life_status_word != 4'h0);
   endproperty
   a_alarm_any: assert property (p_alarm_any) else $error("alarm does not follow flags"); // RULE_02

   property p_term_src;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (func_reg[0] == CODE_ALARM_SRC) |-> o_term_out[0] == o_life_alarm_out;
   endproperty
   a_term_src: assert property (p_term_src) else $error("source terminal wrong"); // RULE_03

   property p_term_sink;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (func_reg[1] == CODE_ALARM_SINK) |-> o_term_out[1] != o_life_alarm_out;
   endproperty
   a_term_sink: assert property (p_term_sink) else $error("sink terminal not inverted"); // RULE_18

   property p_inrush_step;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (inrush_wrap && inrush_life_pct_reg != 7'h00)
      |=> inrush_life_pct_reg == $past(inrush_life_pct_reg) - 7'h01;
   endproperty
   a_inrush_step: assert property (p_inrush_step) else $error("inrush life not lowered"); // RULE_04

   property p_ctrl_step;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_ctrl_cap_wear && ctrl_cap_life_pct_reg > PCT_CTRL_LIM)
      |=> ctrl_cap_life_pct_reg == $past(ctrl_cap_life_pct_reg) - 7'h01;
   endproperty
   a_ctrl_step: assert property (p_ctrl_step) else $error("control cap life not lowered"); // RULE_06

   property p_no_write_status;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wr && i_wb_adr == ADR_MEAS_CTRL && i_wb_dat[3:0] != MC_IDLE && i_wb_dat[3:0] != MC_START
       && (meas_reg == S_IDLE || meas_reg == S_START) && !pdown)
      |=> meas_reg == $past(meas_reg);
   endproperty
   a_no_write_status: assert property (p_no_write_status) else $error("status code written"); // RULE_10

   property p_start_on_pdown;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (meas_reg == S_START && !pdown && !wr_ctrl) |=> meas_reg == S_START;
   endproperty
   a_start_on_pdown: assert property (p_start_on_pdown) else $error("started early"); // RULE_11

   property p_run_forces;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (meas_reg == S_MEAS && i_run_cmd && !wr_ctrl) |=> meas_code(meas_reg) == MC_FORCED;
   endproperty
   a_run_forces: assert property (p_run_forces) else $error("run did not force end"); // RULE_13

   property p_pup_forces;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (meas_reg == S_MEAS && pup && !wr_ctrl) |=> meas_reg == S_FORCED;
   endproperty
   a_pup_forces: assert property (p_pup_forces) else $error("power return not forced"); // RULE_13

   property p_dc_bound;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (meas_reg == S_MEAS) |-> dc_cnt_reg < 32'(DC_CYC);
   endproperty
   a_dc_bound: assert property (p_dc_bound) else $error("dc injection overran"); // RULE_12

   property p_life_range;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      inrush_life_pct_reg <= PCT_FULL && ctrl_cap_life_pct_reg <= PCT_FULL
      && main_cap_life_pct_reg <= PCT_FULL;
   endproperty
   a_life_range: assert property (p_life_range) else $error("life value out of range"); // RULE_17

   property p_done_update;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (meas_end && meas_next == S_DONE && !wr_ctrl && i_main_cap_meas_pct <= PCT_FULL)
      |=> main_cap_life_pct_reg == $past(i_main_cap_meas_pct) && o_dc_inject == 1'b0;
   endproperty
   a_done_update: assert property (p_done_update) else $error("main cap life not taken"); // RULE_08
endmodule

// File: dv/plam_ctrl_input.sv
// external controller input that samples the three alarm terminals
`timescale 1ns/1ns
module plam_ctrl_input
#(
   parameter int N = 3
)(
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   input  wire logic [N-1:0] i_term,
   output logic      [N-1:0] o_seen
);
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         o_seen <= '0;
      end
      else
      begin
         o_seen <= i_term;
      end
   end
endmodule

// File: dv/plam_top_test.sv
// self-checking bench for the part life alarm monitor
`timescale 1ns/1ns
module plam_top_test;
   import plam_pkg::*;
   localparam int DCC = 20;
   logic        clk, rst_n, cyc, stb, we, ack, ins, wear, pwr, run, shut, flt, mot, rot;
   logic        dc, alarm, fanf, fanf2, irq;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, odat;
   logic [3:0]  sel;
   logic [6:0]  mpct, fan, fan2;
   logic [2:0]  term, seen;
   logic [3:0]  mexp [6] = '{4'h8, 4'h8, 4'h9, 4'h9, 4'h8, 4'h8};
   int          num_errors, comparisons, n;

   plam_top #(.DC_CYC(DCC), .INRUSH_PER(4)) dut_u (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
      .o_wb_dat(odat), .o_wb_ack(ack), .i_inrush_close(ins), .i_ctrl_cap_wear(wear),
      .i_main_cap_meas_pct(mpct), .i_fan_speed_pct(fan), .i_power_on(pwr),
      .i_run_cmd(run), .i_output_shutoff_in(shut), .i_fault_stop(flt),
      .i_motor_present(mot), .i_motor_rotating(rot), .o_dc_inject(dc),
      .o_life_alarm_out(alarm), .o_term_out(term), .o_fan_fault_indication(fanf),
      .o_irq(irq));

   plam_ctrl_input #(.N(3)) ctrl_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_term(term),
      .o_seen(seen));

   // second unit with two fans, only its fan fault output is watched
   plam_top #(.NUM_FANS(2), .DC_CYC(DCC), .INRUSH_PER(4)) dut_multi_u (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(1'b0), .i_wb_stb(1'b0),
      .i_wb_we(1'b0), .i_wb_adr(8'h00), .i_wb_dat(32'h0000_0000), .i_wb_sel(4'h0),
      .o_wb_dat(), .o_wb_ack(), .i_inrush_close(1'b0), .i_ctrl_cap_wear(1'b0),
      .i_main_cap_meas_pct(mpct), .i_fan_speed_pct({fan2, fan}), .i_power_on(pwr),
      .i_run_cmd(run), .i_output_shutoff_in(shut), .i_fault_stop(flt),
      .i_motor_present(mot), .i_motor_rotating(rot), .o_dc_inject(),
      .o_life_alarm_out(), .o_term_out(), .o_fan_fault_indication(fanf2),
      .o_irq());

   task automatic end_of_test();
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && k < 50)
      begin
         k++;
         @(posedge clk);
      end
      chk(k < 50, 1);
      if (k >= 50)
         end_of_test();
      rdat = odat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask

   task automatic st(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic pulse(input logic w, input int c);
      repeat (c)
      begin
         @(posedge clk);
         ins <= !w;
         wear <= w;
      end
      @(posedge clk);
      ins <= 1'b0;
      wear <= 1'b0;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test();
   end

   initial
   begin
      {rst_n, cyc, stb, we, ins, wear, run, shut, flt, rot} = '0;
      {pwr, mot} = 2'b11;
      adr = 8'h00;
      wdat = 32'h0000_0000;
      sel = 4'hF;
      mpct = 7'h64;
      fan = 7'h64;
      fan2 = 7'h64;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      foreach (mexp[i])
      begin
         rdchk(ADR_INRUSH + 8'(4 * i), (i < 3) ? 32'h0000_0064 : 32'h0000_0000);
      end
      wb(1'b1, ADR_INRUSH, 32'h0000_0005);
      rdchk(ADR_INRUSH, 32'h0000_0064);
      rdchk(8'h30, 32'h0000_0000);
      wb(1'b1, ADR_FUNC_A, {24'h0, CODE_ALARM_SRC});
      wb(1'b1, ADR_FUNC_B, {24'h0, CODE_ALARM_SINK});
      wb(1'b1, ADR_IRQ_EN, 32'h0000_0008);
      st(2);
      chk(seen, 3'b010);
      @(posedge clk);
      fan2 <= 7'h33;
      st(1);
      chk(fanf2, 1'b0);
      @(posedge clk);
      fan2 <= 7'h32;
      fan <= 7'h32;
      st(1);
      chk({fanf2, fanf}, 2'b10);
      @(posedge clk);
      fan2 <= 7'h64;
      fan <= 7'h64;
      pulse(1'b0, 4);
      rdchk(ADR_INRUSH, 32'h0000_0063);
      pulse(1'b0, 355);
      rdchk(ADR_INRUSH, 32'h0000_000B);
      rdchk(ADR_STATUS, 32'h0000_0000);
      pulse(1'b0, 1);
      rdchk(ADR_STATUS, 32'h0000_0008);
      st(2);
      chk({alarm, irq, seen}, 5'b11001);
      wb(1'b1, ADR_IRQ_CLR, 32'h0000_0008);
      st(1);
      chk(irq, 1'b0);
      pulse(1'b1, 90);
      rdchk(ADR_STATUS, 32'h0000_0008);
      pulse(1'b1, 1);
      rdchk(ADR_CTRL_CAP, 32'h0000_0009);
      rdchk(ADR_STATUS, 32'h0000_0009);
      rdchk(ADR_IRQ_STAT, 32'h0000_0001);
      chk(irq, 1'b0);
      wb(1'b1, ADR_IRQ_EN, 32'h0000_0001);
      st(1);
      chk(irq, 1'b1);
      @(posedge clk);
      fan <= 7'h29;
      st(2);
      chk(fanf, 1'b0);
      @(posedge clk);
      fan <= 7'h28;
      st(2);
      chk(fanf, 1'b1);
      rdchk(ADR_STATUS, 32'h0000_000D);
      wb(1'b1, ADR_MEAS_CTRL, 32'h0000_0001);
      wb(1'b1, ADR_MEAS_CTRL, 32'h0000_0002);
      st(3);
      chk(dc, 1'b0);
      rdchk(ADR_MEAS_CTRL, 32'h0000_0001);
      mpct <= 7'h55;
      pwr <= 1'b0;
      n = 0;
      do
      begin
         st(1);
         n++;
      end while (dc === 1'b1 && n < 100);
      chk(n >= DCC && n <= DCC + 2, 1);
      rdchk(ADR_MEAS_CTRL, 32'h0000_0003);
      rdchk(ADR_MAIN_CAP, 32'h0000_0055);
      rdchk(ADR_STATUS, 32'h0000_000F);
      chk(alarm, 1'b1);
      for (int k = 0; k < 6; k++)
      begin
         pwr <= 1'b1;
         mpct <= 7'h20;
         wb(1'b1, ADR_MEAS_CTRL, 32'h0000_0001);
         shut <= (k == 0);
         flt <= (k == 1);
         rot <= (k == 2);
         mot <= (k != 3);
         @(posedge clk);
         pwr <= 1'b0;
         repeat (3) @(posedge clk);
         run <= (k == 4);
         pwr <= (k == 5);
         repeat (3) @(posedge clk);
         {shut, flt, rot, run} <= '0;
         mot <= 1'b1;
         rdchk(ADR_MEAS_CTRL, {28'h0, mexp[k]});
      end
      rdchk(ADR_MAIN_CAP, 32'h0000_0055);
      end_of_test();
   end
endmodule
